// [include/plsu_defs.svh]
// constants for the programmable logic slice unit
`ifndef PLSU_DEFS_SVH
`define PLSU_DEFS_SVH
`define PLSU_TABLE_INPUTS 4
`define PLSU_TABLE_DEPTH  16
`define PLSU_NUM_TABLES   8
`define PLSU_NUM_SLICES   4
`define PLSU_REG_SLICES   3
`define PLSU_RAM_TABLES   4
`define PLSU_REG_BITS     2
`endif

// [include/plsu_pkg.sv]
// types for the programmable logic slice unit
package plsu_pkg;
  typedef enum logic [3:0] {
    PLSU_MODE_LOGIC  = 4'h1,
    PLSU_MODE_RIPPLE = 4'h2,
    PLSU_MODE_RAM    = 4'h4,
    PLSU_MODE_ROM    = 4'h8
  } plsu_mode_t;
  typedef enum logic [5:0] {
    PLSU_ARITH_ADD    = 6'h01,
    PLSU_ARITH_SUB    = 6'h02,
    PLSU_ARITH_ADDSUB = 6'h04,
    PLSU_ARITH_MULT   = 6'h08,
    PLSU_ARITH_MSUP   = 6'h10,
    PLSU_ARITH_CMP    = 6'h20
  } plsu_arith_t;
  typedef enum logic [3:0] {
    PLSU_COUNT_NONE   = 4'h1,
    PLSU_COUNT_UP     = 4'h2,
    PLSU_COUNT_DOWN   = 4'h4,
    PLSU_COUNT_UPDOWN = 4'h8
  } plsu_count_t;
endpackage

// [rtl/plsu_logic_ram_unit.sv]
// four-slice logic_ram_unit: tables, ripple arithmetic, lutram, rom
//
// Summary of operation
// - four modes per unit: logic, ripple arithmetic, distributed ram, rom
// - each four_input_table returns its programmed bit for 16 indices
// - two tables of a slice merge into one five_input_table
// - six, seven and eight_input_table chain slices; eight needs a neighbour
// - ripple slice adds, subtracts, or adds/subtracts under dynamic control
// - ripple slice counts up, down or both, with asynchronous clear
// - ripple up/down counter preloads synchronously on the clock edge
// - ripple slice reports a>=b, a!=b and a<=b
// - ripple slice gives multiplier building block and multiplier support
// - fast carry: each slice yields carry generate and carry propagate
// - ram mode: slices 0 and 1 tables form a 16x4 single_port_lutram
// - slice 2 supplies ram address and write control
// - pseudo_dual_lutram: slice 0 read-write, slice 1 read-only port
// - table contents load configured values before user operation
// - slice registers set or reset to configured state entering user mode
// - slice 3 has no registers; unselected control input reads as one
`timescale 1ns/1ns
`include "plsu_defs.svh"

module plsu_logic_ram_unit #(
  parameter int TABLE_INPUTS = `PLSU_TABLE_INPUTS
) (
  // clock and reset
  input  logic                 clock,
  input  logic                 reset,
  // configuration
  input  plsu_pkg::plsu_mode_t  cfg_mode,
  input  plsu_pkg::plsu_arith_t cfg_arith,
  input  plsu_pkg::plsu_count_t cfg_count,
  input  logic                 cfg_pseudo_dual,
  input  logic [127:0]         cfg_table,
  input  logic [5:0]           cfg_reg_init,
  input  logic [2:0]           cfg_ce_sel,
  // table inputs
  input  logic [31:0]          table_index,
  input  logic [3:0]           mux_sel,
  input  logic [1:0]           sel6,
  input  logic                 sel7,
  input  logic                 sel8,
  input  logic                 cascade_in,
  // ripple controls
  input  logic                 carry_in,
  input  logic                 add_not_sub,
  input  logic                 count_up,
  input  logic                 count_load,
  input  logic                 count_clear,
  input  logic [2:0]           slice_ce,
  // lutram write side
  input  logic                 ram_we,
  input  logic [3:0]           ram_wdata,
  // table results
  output logic [7:0]           table_out,
  output logic [3:0]           five_out,
  output logic [1:0]           six_out,
  output logic                 seven_out,
  output logic                 eight_out,
  // ripple results
  output logic [7:0]           sum,
  output logic                 carry_out,
  output logic [3:0]           carry_gen,
  output logic [3:0]           carry_prop,
  output logic [3:0]           cmp_ge,
  output logic [3:0]           cmp_ne,
  output logic [3:0]           cmp_le,
  // slice registers
  output logic [5:0]           reg_q
);

  ////////////////////////////////////////////////////////////////////////////
  // parameter check and common decode

  if (TABLE_INPUTS != `PLSU_TABLE_INPUTS)
  begin : g_bad_param
    $error("only four-input tables are supported");
  end

  function automatic logic table_read(input logic [15:0] cells,
                                      input logic [3:0]  idx);
    table_read = cells[idx];
  endfunction

  localparam int NT = `PLSU_NUM_TABLES;
  localparam int TD = `PLSU_TABLE_DEPTH;
  localparam int RB = `PLSU_REG_BITS;

  logic         is_ripple;
  logic         is_ram;
  logic [2:0]   ce_eff;
  logic [3:0]   ram_waddr;
  logic [3:0]   ram_raddr;
  logic         ram_write;
  logic         clear_async;
  logic [127:0] table_contents;
  logic [4:0]   chain;

  assign is_ripple = (cfg_mode == plsu_pkg::PLSU_MODE_RIPPLE);
  assign is_ram    = (cfg_mode == plsu_pkg::PLSU_MODE_RAM);
  assign ce_eff    = ~cfg_ce_sel | slice_ce;
  assign ram_waddr = table_index[19:16];
  assign ram_raddr = table_index[11:8];
  // rom and logic modes never reach the write term
  assign ram_write = is_ram && ram_we && ce_eff[2];
  // clear is gated by static configuration only, so it cannot glitch
  assign clear_async = count_clear && is_ripple &&
                       (cfg_count != plsu_pkg::PLSU_COUNT_NONE);

  ////////////////////////////////////////////////////////////////////////////
  // table storage and read

  for (genvar t = 0; t < NT; t++)
  begin : g_table
    logic [15:0] cells;
    logic [3:0]  idx;
    logic        wbit;
    logic        wen;

    if (t < `PLSU_RAM_TABLES)
    begin : g_wr
      // pseudo dual mirrors port bits into slice 1 for the read-only port
      assign wbit = (cfg_pseudo_dual && t >= 2) ? ram_wdata[t%2]
                                                : ram_wdata[t];
      assign wen  = ram_write;
      assign idx  = !is_ram ? table_index[t*4 +: 4] :
                    (cfg_pseudo_dual && t >= 2) ? ram_raddr
                                                : ram_waddr;
    end
    else
    begin : g_ro
      assign wbit = 1'b0;
      assign wen  = 1'b0;
      assign idx  = table_index[t*4 +: 4];
    end

    always_ff @(posedge clock)
    begin
      if (reset)
        cells <= cfg_table[t*TD +: TD];
      else if (wen)
        cells[ram_waddr] <= wbit;
    end

    assign table_contents[t*TD +: TD] = cells;
    assign table_out[t] = table_read(cells, idx);
  end

  ////////////////////////////////////////////////////////////////////////////
  // wide functions

  for (genvar s = 0; s < `PLSU_NUM_SLICES; s++)
  begin : g_five
    assign five_out[s] = mux_sel[s] ? table_out[2*s+1]
                                    : table_out[2*s];
  end

  assign six_out[0] = sel6[0] ? five_out[1] : five_out[0];
  assign six_out[1] = sel6[1] ? five_out[3] : five_out[2];
  assign seven_out  = sel7 ? six_out[1] : six_out[0];
  // the eighth input needs the seven-input half of a neighbouring unit
  assign eight_out  = sel8 ? cascade_in : seven_out;

  ////////////////////////////////////////////////////////////////////////////
  // ripple arithmetic, one 2-bit cell per slice

  assign chain[0]  = carry_in;
  assign carry_out = chain[4];

  for (genvar s = 0; s < `PLSU_NUM_SLICES; s++)
  begin : g_arith
    logic [1:0] op_a;
    logic [1:0] op_b;
    logic [1:0] pp;
    logic [1:0] x;
    logic [1:0] y;
    logic [2:0] total;
    logic [1:0] g;
    logic [1:0] p;

    assign op_a = table_index[s*8 +: 2];
    assign op_b = table_index[s*8+4 +: 2];
    assign pp   = op_a & {2{mux_sel[s]}};

    always_comb
    begin
      x = op_a;
      y = op_b;
      unique case (cfg_arith)
        plsu_pkg::PLSU_ARITH_ADD:    y = op_b;
        plsu_pkg::PLSU_ARITH_SUB:    y = ~op_b;
        plsu_pkg::PLSU_ARITH_ADDSUB: y = add_not_sub ? op_b : ~op_b;
        plsu_pkg::PLSU_ARITH_MULT:
        begin
          x = op_b;
          y = pp;
        end
        plsu_pkg::PLSU_ARITH_MSUP:
        begin
          x = pp;
          y = 2'h0;
        end
        plsu_pkg::PLSU_ARITH_CMP:    y = ~op_b;
        default:                     y = op_b;
      endcase
    end

    assign total = {1'b0, x} + {1'b0, y} + {2'h0, chain[s]};
    assign sum[s*2 +: 2] = total[1:0];
    assign chain[s+1]    = total[2];
    assign g = x & y;
    assign p = x ^ y;
    assign carry_gen[s]  = g[1] | (p[1] & g[0]);
    assign carry_prop[s] = p[1] & p[0];
    assign cmp_ge[s] = (op_a >= op_b);
    assign cmp_le[s] = (op_a <= op_b);
    assign cmp_ne[s] = (op_a != op_b);
  end

  ////////////////////////////////////////////////////////////////////////////
  // slice registers, slices 0 to 2 only

  for (genvar s = 0; s < `PLSU_REG_SLICES; s++)
  begin : g_reg
    logic [1:0] q;
    logic [1:0] next_q;
    logic [1:0] load_val;
    logic       counting;

    assign load_val = table_index[s*8 +: 2];
    assign counting = is_ripple &&
                      (cfg_count != plsu_pkg::PLSU_COUNT_NONE);

    always_comb
    begin
      next_q = q;
      if (counting && count_load)
        next_q = load_val;
      else if (counting)
      begin
        unique case (cfg_count)
          plsu_pkg::PLSU_COUNT_UP:     next_q = q + 2'h1;
          plsu_pkg::PLSU_COUNT_DOWN:   next_q = q - 2'h1;
          plsu_pkg::PLSU_COUNT_UPDOWN:
            next_q = count_up ? q + 2'h1 : q - 2'h1;
          default:                     next_q = q;
        endcase
      end
      else if (is_ripple)
        next_q = sum[s*2 +: 2];
      else
        next_q = {table_out[2*s+1], table_out[2*s]};
    end

    always_ff @(posedge clock or posedge clear_async)
    begin
      if (clear_async)
        q <= 2'h0;
      else if (reset)
        q <= cfg_reg_init[s*RB +: RB];
      else if (ce_eff[s])
        q <= next_q;
    end

    assign reg_q[s*RB +: RB] = q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_ROM_NO_WRITE: assert property (
    @(posedge clock) disable iff (reset)
    (cfg_mode == plsu_pkg::PLSU_MODE_ROM) && ram_we
      |=> $stable(table_contents))
    else $error("rom contents changed");

  AST_RAM_WRITE: assert property (
    @(posedge clock) disable iff (reset)
    ram_write |=> table_contents[$past(ram_waddr)] == $past(ram_wdata[0]))
    else $error("lutram write lost");

  AST_SPR_READ: assert property (
    @(posedge clock) disable iff (reset)
    is_ram && !cfg_pseudo_dual
      |-> table_out[3:0] == {table_contents[48 + ram_waddr],
                             table_contents[32 + ram_waddr],
                             table_contents[16 + ram_waddr],
                             table_contents[ram_waddr]})
    else $error("single port read wrong");

  AST_PSEUDO_DUAL_LUTRAM_MIRROR: assert property (
    @(posedge clock) disable iff (reset)
    ram_write && cfg_pseudo_dual
      |=> table_contents[32 + $past(ram_waddr)] == $past(ram_wdata[0]))
    else $error("read-only port not mirrored");

  AST_INIT_TABLE: assert property (
    @(posedge clock) disable iff (reset)
    $fell(reset) |-> table_contents == $past(cfg_table))
    else $error("table not initialised");

  AST_REG_INIT: assert property (
    @(posedge clock) disable iff (reset)
    $fell(reset) && !clear_async |-> reg_q == $past(cfg_reg_init))
    else $error("register init state wrong");

  AST_CE_DEFAULT: assert property (
    @(posedge clock) disable iff (reset)
    !cfg_ce_sel[0] && (cfg_mode == plsu_pkg::PLSU_MODE_LOGIC)
      ##1 !clear_async
      |-> reg_q[1:0] == $past(table_out[1:0]))
    else $error("unselected enable not one");

  AST_COUNT_UP: assert property (
    @(posedge clock) disable iff (reset)
    is_ripple && cfg_count == plsu_pkg::PLSU_COUNT_UP && ce_eff[0] &&
    !count_load && !clear_async ##1 !clear_async
      |-> reg_q[1:0] == $past(reg_q[1:0]) + 2'h1)
    else $error("up count wrong");

  AST_PRELOAD: assert property (
    @(posedge clock) disable iff (reset)
    is_ripple && cfg_count != plsu_pkg::PLSU_COUNT_NONE && count_load &&
    ce_eff[0] && !clear_async ##1 !clear_async
      |-> reg_q[1:0] == $past(table_index[1:0]))
    else $error("preload missed");

  AST_CMP_TIE: assert property (
    @(posedge clock) disable iff (reset)
    (cfg_arith == plsu_pkg::PLSU_ARITH_CMP) && carry_in
      |-> cmp_ge[0] == chain[1])
    else $error("compare flags inconsistent");

  AST_FAST_CARRY: assert property (
    @(posedge clock) disable iff (reset)
    (&carry_prop) |-> carry_out == carry_in)
    else $error("carry propagate wrong");

  AST_FIVE_SEL: assert property (
    @(posedge clock) disable iff (reset)
    mux_sel[1] |-> five_out[1] == table_out[3])
    else $error("five input select wrong");

  COV_PSEUDO_DUAL_LUTRAM_WRITE: cover property (
    @(posedge clock) disable iff (reset)
    ram_write && cfg_pseudo_dual ##1 ram_write);

  COV_COUNT_WRAP: cover property (
    @(posedge clock) disable iff (reset)
    is_ripple && reg_q[1:0] == 2'h3 ##1 reg_q[1:0] == 2'h0);

  COV_EIGHT_CASCADE: cover property (
    @(posedge clock) disable iff (reset)
    sel8 && cascade_in && eight_out);

endmodule // plsu_logic_ram_unit

// [sim/plsu_neighbour.sv]
// neighbour slice model feeding the cascade input of the unit
`timescale 1ns/1ns

module plsu_neighbour (
  // neighbour table lookup
  input  wire logic [3:0] index,
  output logic            cascade
);
  // fixed neighbour function; high at index 15, low at index 0, so the
  // all-high and all-low wide cases stay valid whatever the mux order
  localparam logic [15:0] CONTENTS = 16'hc3a8;

  assign cascade = CONTENTS[index];
endmodule // plsu_neighbour

// [sim/programmable_logic_slice_bench.sv]
// self-checking bench for the four-slice logic ram unit
`timescale 1ns/1ns

module programmable_logic_slice_bench;
  logic                  clock, reset, pd, sel7, sel8, casc, cin, ans;
  logic                  cup, cload, cclr, we, seven, eight, cout;
  plsu_pkg::plsu_mode_t  mode;
  plsu_pkg::plsu_arith_t arith;
  plsu_pkg::plsu_count_t count;
  logic [127:0]          tab;
  logic [5:0]            rinit, reg_q;
  logic [2:0]            ce_sel, slice_ce;
  logic [31:0]           idx;
  logic [3:0]            msel, wdata, five, cg, cp, ge, ne, le;
  logic [1:0]            sel6, six, a, b;
  logic [7:0]            tout, sum, e;
  int                    miscompares, comparisons;

  plsu_logic_ram_unit DUT (.clock(clock), .reset(reset), .cfg_mode(mode),
    .cfg_arith(arith), .cfg_count(count), .cfg_pseudo_dual(pd),
    .cfg_table(tab), .cfg_reg_init(rinit), .cfg_ce_sel(ce_sel),
    .table_index(idx), .mux_sel(msel), .sel6(sel6), .sel7(sel7),
    .sel8(sel8), .cascade_in(casc), .carry_in(cin), .add_not_sub(ans),
    .count_up(cup), .count_load(cload), .count_clear(cclr),
    .slice_ce(slice_ce), .ram_we(we), .ram_wdata(wdata), .table_out(tout),
    .five_out(five), .six_out(six), .seven_out(seven), .eight_out(eight),
    .sum(sum), .carry_out(cout), .carry_gen(cg), .carry_prop(cp),
    .cmp_ge(ge), .cmp_ne(ne), .cmp_le(le), .reg_q(reg_q));
  plsu_neighbour NB (.index(idx[3:0]), .cascade(casc));

  always #20 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////
  task step;
    @(negedge clock);
  endtask

  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // expected table bits from the configured image, all tables at index i
  function automatic logic [7:0] tbits(input logic [3:0] i);
    for (int t = 0; t < 8; t++)
      tbits[t] = tab[t*16+i];
  endfunction

  task final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task t_logic;
    mode = plsu_pkg::PLSU_MODE_LOGIC;
    msel = 4'h5;
    for (int i = 0; i < 16; i++)
    begin
      step;
      idx = {8{i[3:0]}};
      #1 e = tbits(i[3:0]);
      chk("table_out", e, tout);
      for (int s = 0; s < 4; s++)
        chk("five_out", {7'h0, e[2*s+msel[s]]}, {7'h0, five[s]});
      step;
      chk("reg_q logic", {2'h0, e[5:0]}, {2'h0, reg_q});
    end
    // every table and the neighbour high at 15, low at 0
    sel6 = 2'h2;
    sel7 = 1'b1;
    sel8 = 1'b1;
    idx = {8{4'hf}};
    #1 chk("wide high", 8'h0f, {4'h0, six, seven, eight});
    step;
    idx = 32'h0;
    #1 chk("wide low", 8'h00, {4'h0, six, seven, eight});
    step;
    $display("test logic done");
  endtask

  task t_arith;
    mode = plsu_pkg::PLSU_MODE_RIPPLE;
    for (int k = 0; k < 16; k++)
    begin
      a = k[1:0];
      b = k[3:2];
      step;
      idx = {26'h0, b, 2'h0, a};
      arith = plsu_pkg::PLSU_ARITH_ADD;
      cin = 1'b0;
      #1 chk("add", {6'h0, 2'(a + b)}, {6'h0, sum[1:0]});
      chk("gen", {7'h0, 3'(a) + 3'(b) > 3'h3}, {7'h0, cg[0]});
      chk("prop", {7'h0, (a ^ b) == 2'h3}, {7'h0, cp[0]});
      step;
      arith = plsu_pkg::PLSU_ARITH_SUB;
      cin = 1'b1;
      #1 chk("sub", {6'h0, 2'(a - b)}, {6'h0, sum[1:0]});
      step;
      arith = plsu_pkg::PLSU_ARITH_ADDSUB;
      ans = k[0];
      cin = ~k[0];
      e = k[0] ? 8'(a + b) : 8'(a - b);
      #1 chk("addsub", {6'h0, e[1:0]}, {6'h0, sum[1:0]});
      step;
      arith = plsu_pkg::PLSU_ARITH_CMP;
      cin = 1'b1;
      e = {5'h0, a >= b, a != b, a <= b};
      #1 chk("cmp", e, {5'h0, ge[0], ne[0], le[0]});
      step;
      arith = plsu_pkg::PLSU_ARITH_MULT;
      msel = {3'h0, k[0]};
      cin = 1'b0;
      e = 8'(b + (a & {2{k[0]}}));
      #1 chk("mult", {6'h0, e[1:0]}, {6'h0, sum[1:0]});
      step;
      arith = plsu_pkg::PLSU_ARITH_MSUP;
      cin = 1'b1;
      e = 8'((a & {2{k[0]}}) + 2'h1);
      #1 chk("msup", {6'h0, e[1:0]}, {6'h0, sum[1:0]});
    end
    step;
    $display("test arith done");
  endtask

  task t_count;
    mode = plsu_pkg::PLSU_MODE_RIPPLE;
    count = plsu_pkg::PLSU_COUNT_UPDOWN;
    step;
    idx = 32'h2;
    cup = 1'b1;
    cload = 1'b1;
    step;
    chk("preload", 8'h2, {6'h0, reg_q[1:0]});
    cload = 1'b0;
    step;
    chk("count up", 8'h3, {6'h0, reg_q[1:0]});
    cup = 1'b0;
    step;
    chk("count down", 8'h2, {6'h0, reg_q[1:0]});
    ce_sel = 3'h1;
    step;
    chk("enable low", 8'h2, {6'h0, reg_q[1:0]});
    ce_sel = 3'h0;
    count = plsu_pkg::PLSU_COUNT_UP;
    step;
    chk("up only", 8'h3, {6'h0, reg_q[1:0]});
    cclr = 1'b1;
    #1 chk("async clear", 8'h0, {6'h0, reg_q[1:0]});
    step;
    cclr = 1'b0;
    $display("test count done");
  endtask

  task t_ram;
    mode = plsu_pkg::PLSU_MODE_RAM;
    we = 1'b1;
    idx = {8{4'h5}};
    wdata = 4'ha;
    step;
    idx = {8{4'h6}};
    wdata = 4'h3;
    step;
    we = 1'b0;
    idx = {8{4'h5}};
    e = (tbits(4'h5) & 8'hf0) | 8'h0a;
    #1 chk("spr 5", e, tout);
    step;
    idx = {8{4'h6}};
    e = (tbits(4'h6) & 8'hf0) | 8'h03;
    #1 chk("spr 6", e, tout);
    step;
    pd = 1'b1;
    we = 1'b1;
    idx = {8{4'h9}};
    // read port pointed elsewhere so a mirror write to it would show
    idx[11:8] = 4'h4;
    wdata = 4'h2;
    step;
    we = 1'b0;
    idx[11:8] = 4'h9;
    #1 chk("pseudo_dual_lutram", 8'h0a, {4'h0, tout[3:0]});
    step;
    idx[11:8] = 4'h7;
    e = {6'h0, tab[3*16+7], tab[2*16+7]};
    #1 chk("pseudo_dual_lutram read port", e, {6'h0, tout[3:2]});
    step;
    pd = 1'b0;
    $display("test ram done");
  endtask

  task t_rom;
    reset = 1'b1;
    repeat (10) step;
    reset = 1'b0;
    idx = {8{4'h5}};
    #1 chk("reload", tbits(4'h5), tout);
    chk("reg_q reload", 8'h2d, {2'h0, reg_q});
    step;
    mode = plsu_pkg::PLSU_MODE_ROM;
    we = 1'b1;
    wdata = 4'hf;
    step;
    we = 1'b0;
    #1 chk("rom", tbits(4'h5), tout);
    $display("test rom done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {clock, pd, sel7, sel8, cin, ans, cup, cload, cclr, we} = '0;
    {sel6, msel, wdata, idx, ce_sel, slice_ce} = '0;
    miscompares = 0;
    comparisons = 0;
    reset = 1'b1;
    mode = plsu_pkg::PLSU_MODE_LOGIC;
    arith = plsu_pkg::PLSU_ARITH_ADD;
    count = plsu_pkg::PLSU_COUNT_NONE;
    tab = 128'h96c4_a5b2_f00e_8e3c_c35a_b7d6_9998_e1f0;
    rinit = 6'h2d;
    repeat (10) step;
    chk("reg_q init", 8'h2d, {2'h0, reg_q});
    reset = 1'b0;
    t_logic;
    t_arith;
    t_count;
    t_ram;
    t_rom;
    final_report;
  end

  // the tests need under two hundred cycles; allow ample margin
  initial
  begin
    #400000;
    miscompares++;
    final_report;
  end
endmodule // programmable_logic_slice_bench
